/* File: inc/ppd_pkg.sv */
// Constants and state type shared by the port pin direction logic.
package ppd_pkg;

  localparam int unsigned PPD_LINES    = 8;
  localparam int unsigned PPD_ADDR_W   = 20;

  // Bit positions of the mixed port.
  localparam int unsigned PPD_BIT_RX   = 0;
  localparam int unsigned PPD_BIT_TX   = 1;
  localparam int unsigned PPD_BIT_BCK1 = 2;
  localparam int unsigned PPD_BIT_INT1 = 3;
  localparam int unsigned PPD_BIT_CTS1 = 4;
  localparam int unsigned PPD_BIT_BCK0 = 5;
  localparam int unsigned PPD_BIT_OD6  = 6;
  localparam int unsigned PPD_BIT_OD7  = 7;

  // Lines the mixed port only drives, lines it only samples, its open-drain lines and the lines it reads back.
  localparam logic [7:0] PPD_MIX_OUT_ONLY = 8'h0a;
  localparam logic [7:0] PPD_MIX_IN_ONLY  = 8'h34;
  localparam logic [7:0] PPD_MIX_OPEN_DR  = 8'hc0;
  localparam logic [7:0] PPD_MIX_READABLE = 8'hf5;

  // Values after reset.
  localparam logic [7:0] PPD_RST_OUT_PIN  = 8'hff;
  localparam logic [7:0] PPD_RST_MIX_OUT  = 8'hff;
  localparam logic [7:0] PPD_RST_MIX_OE   = 8'h00;
  localparam logic [7:0] PPD_RST_MIX_IN   = 8'h00;
  localparam logic       PPD_RST_RX       = 1'h1;
  localparam logic       PPD_RST_CTS_N    = 1'h1;
  localparam logic       PPD_RST_BCLK     = 1'h0;

  typedef struct packed {
    logic [7:0] out_pin;
    logic [7:0] mix_out;
    logic [7:0] mix_oe;
    logic [7:0] mix_in;
    logic       serial_rx;
    logic       serial_serial_one_baud_clock;
    logic       serial_cts_n;
    logic       serial_serial_zero_baud_clock;
  } ppd_state_t;

endpackage

/* File: src/ppd_port_pins.sv */
// Pin logic for the output-only port and the mixed-direction port.
`timescale 1ns/100ps
// Summary of operation
// - Each output port line works alone as a general-purpose output.
// - Select-mode output line goes low during bus cycles inside its programmed range.
// - Mixed bit 0 can be driven as output and sampled as input.
// - Mixed bits 1 and 3 are outputs only, no input path.
// - Mixed bits 2, 4, 5 are inputs only, never driven in port mode.
// - Mixed bits 6, 7 are open drain: pull low or release, sampled.
module ppd_port_pins #(
  parameter int unsigned ADDR_W = 20
) (
  input  wire logic                                   i_clk,
  input  wire logic                                   i_rst_n,
  // Output-only port and its select alternate function.
  input  wire logic [ppd_pkg::PPD_LINES-1:0]          i_out_port_value,
  input  wire logic [ppd_pkg::PPD_LINES-1:0]          i_out_port_sel_mode,
  input  wire logic                                   i_bus_cycle,
  input  wire logic                                   i_bus_is_io,
  input  wire logic [ADDR_W-1:0]                      i_bus_addr,
  input  wire logic [ppd_pkg::PPD_LINES-1:0]          i_sel_enable,
  input  wire logic [ppd_pkg::PPD_LINES-1:0]          i_sel_is_io,
  input  wire logic [ppd_pkg::PPD_LINES-1:0][ADDR_W-1:0] i_sel_start,
  input  wire logic [ppd_pkg::PPD_LINES-1:0][ADDR_W-1:0] i_sel_stop,
  output logic      [ppd_pkg::PPD_LINES-1:0]          o_out_port_pin,
  // Mixed port control from the core.
  input  wire logic [ppd_pkg::PPD_LINES-1:0]          i_mixed_port_value,
  input  wire logic                                   i_mixed_line_zero_drive,
  input  wire logic [5:0]                             i_mixed_periph_mode,
  output logic      [ppd_pkg::PPD_LINES-1:0]          o_mixed_port_read,
  // Mixed port pins, split into level, drive value and drive enable.
  input  wire logic [ppd_pkg::PPD_LINES-1:0]          i_mixed_pin,
  output logic      [ppd_pkg::PPD_LINES-1:0]          o_mixed_pin_out,
  output logic      [ppd_pkg::PPD_LINES-1:0]          o_mixed_pin_oe,
  // Serial unit signals sharing the mixed port.
  input  wire logic                                   i_serial_one_transmit,
  input  wire logic                                   i_serial_one_interrupt,
  output logic                                        o_serial_one_receive,
  output logic                                        o_serial_one_baud_clock,
  output logic                                        o_serial_one_clear_to_send_low,
  output logic                                        o_serial_zero_baud_clock
);
  import ppd_pkg::*;

  // Every output of this module is a field of one registered state word, so each pin
  // changes exactly one clock after the inputs that decide it. Nothing here reaches a
  // pin through a combinational path, which keeps the pin timing the same for every
  // source and keeps glitches from the select decoder off the board.
  //
  // The output-only port has eight lines. Each line chooses on its own between the
  // port value and its generic select. A line in select mode is high while no bus
  // cycle falls in its range, and low for one registered cycle per cycle that does.
  // A disabled select line in select mode simply stays high, so a board that leaves
  // a select unprogrammed never sees a stray low pulse on it.
  //
  // The mixed port is split into four groups by what the pins can physically do.
  // Line 0 is a true input/output line. Its drive is enabled only when the core asks
  // for it and the receive function is not selected; the receive function always
  // turns the driver off so the external transmitter is never fought.
  // Lines 1 and 3 have an output buffer only. Outside reset they are always driven, either with
  // the port value or with the serial transmit and interrupt outputs. Their read
  // back value is forced to zero because there is no input path behind them.
  // Lines 2, 4 and 5 have an input buffer only. Their drive enable is tied off, so
  // no setting of the port value can ever put a level on them.
  // Lines 6 and 7 are open drain. A zero in the port value turns the pull-down on;
  // a one releases the line to its external pull-up. The drive value is held at
  // zero so that an enabled driver can only ever pull low.
  //
  // All readable pin levels are registered once before the core sees them. Inputs
  // are taken as synchronous to the clock, so a single stage is enough here; a pin
  // wired to an asynchronous source needs its own synchroniser outside this block.
  //
  // Serial inputs that share a pin see the pin only while their function is
  // selected. Otherwise they see their idle level: receive and clear to send high,
  // the baud clocks low. This stops a port-mode pin from starting a false frame or
  // a false baud edge in the serial unit when the function is switched on later.
  //
  // Reset puts every output into a safe state. The output port lines go high, which
  // is the inactive level of every select. All mixed drivers are switched off, so
  // nothing is driven until the core has chosen the use of each pin.
  //
  // Hazard: the select decoder compares full addresses against inclusive ranges.
  // Two overlapping ranges will both go low in the same cycle; keeping the ranges
  // apart is up to the software that programs them.
  //
  // Hazard: on line 0 the port driver and an external driver can meet if the core
  // enables the drive while another device is also driving the pin. The block does
  // not detect this; the board must not do it.
  //
  // Limitation: the open-drain lines rise only as fast as their pull-ups allow, so a
  // read straight after a release may still see the old low level.

  ppd_state_t                state;
  ppd_state_t                next_state;
  logic       [PPD_LINES-1:0] sel_hit;

  ppd_select_match #(
    .LINES  (PPD_LINES),
    .ADDR_W (ADDR_W)
  ) u_select_match (
    .i_bus_cycle  (i_bus_cycle),
    .i_bus_is_io  (i_bus_is_io),
    .i_bus_addr   (i_bus_addr),
    .i_sel_enable (i_sel_enable),
    .i_sel_is_io  (i_sel_is_io),
    .i_sel_start  (i_sel_start),
    .i_sel_stop   (i_sel_stop),
    .o_hit        (sel_hit)
  );

  always_comb
  begin
    next_state = state;

    // Output-only port: each line picks its own source.
    for (int i = 0; i < PPD_LINES; i++)
    begin
      if (i_out_port_sel_mode[i])
      begin
        next_state.out_pin[i] = ~sel_hit[i];
      end
      else
      begin
        next_state.out_pin[i] = i_out_port_value[i];
      end
    end

    // Line 0: port I/O under a direction bit, or receive input in peripheral mode.
    next_state.mix_out[PPD_BIT_RX] = i_mixed_port_value[PPD_BIT_RX];
    next_state.mix_oe[PPD_BIT_RX]  = ~i_mixed_periph_mode[PPD_BIT_RX]
                                     & i_mixed_line_zero_drive;

    // Lines 1 and 3: always driven, from port value or peripheral output.
    next_state.mix_out[PPD_BIT_TX]   = i_mixed_periph_mode[PPD_BIT_TX]
                                       ? i_serial_one_transmit
                                       : i_mixed_port_value[PPD_BIT_TX];
    next_state.mix_oe[PPD_BIT_TX]    = 1'b1;
    next_state.mix_out[PPD_BIT_INT1] = i_mixed_periph_mode[PPD_BIT_INT1]
                                       ? i_serial_one_interrupt
                                       : i_mixed_port_value[PPD_BIT_INT1];
    next_state.mix_oe[PPD_BIT_INT1]  = 1'b1;

    // Lines 2, 4 and 5 are never driven.
    next_state.mix_out[PPD_BIT_BCK1] = 1'b0;
    next_state.mix_oe[PPD_BIT_BCK1]  = 1'b0;
    next_state.mix_out[PPD_BIT_CTS1] = 1'b0;
    next_state.mix_oe[PPD_BIT_CTS1]  = 1'b0;
    next_state.mix_out[PPD_BIT_BCK0] = 1'b0;
    next_state.mix_oe[PPD_BIT_BCK0]  = 1'b0;

    // Lines 6 and 7 pull low for a zero and release for a one.
    for (int i = PPD_BIT_OD6; i <= PPD_BIT_OD7; i++)
    begin
      next_state.mix_out[i] = 1'b0;
      next_state.mix_oe[i]  = ~i_mixed_port_value[i];
    end

    // Pin levels read back; output-only lines read as zero.
    next_state.mix_in = i_mixed_pin & PPD_MIX_READABLE;

    // Peripheral inputs see the pin only when selected, else their idle level.
    next_state.serial_rx    = i_mixed_periph_mode[PPD_BIT_RX]
                              ? i_mixed_pin[PPD_BIT_RX] : PPD_RST_RX;
    next_state.serial_serial_one_baud_clock = i_mixed_periph_mode[PPD_BIT_BCK1]
                              ? i_mixed_pin[PPD_BIT_BCK1] : PPD_RST_BCLK;
    next_state.serial_cts_n = i_mixed_periph_mode[PPD_BIT_CTS1]
                              ? i_mixed_pin[PPD_BIT_CTS1] : PPD_RST_CTS_N;
    next_state.serial_serial_zero_baud_clock = i_mixed_periph_mode[PPD_BIT_BCK0]
                              ? i_mixed_pin[PPD_BIT_BCK0] : PPD_RST_BCLK;
  end

  // Reset is synchronous and loads each field with its constant idle value.
  // Between resets the whole state word is taken from the next-state copy.

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state.out_pin      <= PPD_RST_OUT_PIN;
      state.mix_out      <= PPD_RST_MIX_OUT;
      state.mix_oe       <= PPD_RST_MIX_OE;
      state.mix_in       <= PPD_RST_MIX_IN;
      state.serial_rx    <= PPD_RST_RX;
      state.serial_serial_one_baud_clock <= PPD_RST_BCLK;
      state.serial_cts_n <= PPD_RST_CTS_N;
      state.serial_serial_zero_baud_clock <= PPD_RST_BCLK;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign o_out_port_pin                 = state.out_pin;
  assign o_mixed_pin_out                = state.mix_out;
  assign o_mixed_pin_oe                 = state.mix_oe;
  assign o_mixed_port_read              = state.mix_in;
  assign o_serial_one_receive           = state.serial_rx;
  assign o_serial_one_baud_clock        = state.serial_serial_one_baud_clock;
  assign o_serial_one_clear_to_send_low = state.serial_cts_n;
  assign o_serial_zero_baud_clock       = state.serial_serial_zero_baud_clock;

endmodule

/* File: src/ppd_select_match.sv */
// Address range decoder for the eight generic select outputs.
`timescale 1ns/100ps
module ppd_select_match #(
  parameter int unsigned LINES  = 8,
  parameter int unsigned ADDR_W = 20
) (
  input  wire logic                           i_bus_cycle,
  input  wire logic                           i_bus_is_io,
  input  wire logic [ADDR_W-1:0]              i_bus_addr,
  input  wire logic [LINES-1:0]               i_sel_enable,
  input  wire logic [LINES-1:0]               i_sel_is_io,
  input  wire logic [LINES-1:0][ADDR_W-1:0]   i_sel_start,
  input  wire logic [LINES-1:0][ADDR_W-1:0]   i_sel_stop,
  output logic      [LINES-1:0]               o_hit
);

  function automatic logic in_range(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (addr >= lo) && (addr <= hi);
  endfunction

  // A line hits when it is enabled, the cycle is in its space and the address in its range.
  for (genvar g = 0; g < LINES; g++)
  begin : g_hit
    assign o_hit[g] = i_bus_cycle && i_sel_enable[g] && (i_sel_is_io[g] == i_bus_is_io)
                      && in_range(i_bus_addr, i_sel_start[g], i_sel_stop[g]);
  end

endmodule

/* File: tb/ppd_chk.sv */
// Checker for the port pin logic outputs.
`timescale 1ns/100ps
module ppd_chk #(
  parameter int unsigned ADDR_W = 20
) (
  input wire logic i_clk, i_rst_n, i_bus_cycle, i_bus_is_io, i_mixed_line_zero_drive,
  input wire logic i_serial_one_transmit, o_serial_one_receive, o_serial_one_clear_to_send_low,
  input wire logic [ADDR_W-1:0] i_bus_addr,
  input wire logic [7:0][ADDR_W-1:0] i_sel_start, i_sel_stop,
  input wire logic [5:0] i_mixed_periph_mode,
  input wire logic [7:0] i_out_port_value, i_out_port_sel_mode, i_sel_enable, i_sel_is_io,
  input wire logic [7:0] i_mixed_port_value, i_mixed_pin, o_out_port_pin, o_mixed_port_read,
  input wire logic [7:0] o_mixed_pin_out, o_mixed_pin_oe
);
  import ppd_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] hit, hit_q;
  always_comb
    for (int k = 0; k < 8; k++)
      hit[k] = i_bus_cycle && i_sel_enable[k] && i_sel_is_io[k] == i_bus_is_io
        && i_bus_addr >= i_sel_start[k] && i_bus_addr <= i_sel_stop[k];
  always_ff @(posedge i_clk)
    hit_q <= hit;
  // Outputs only follow inputs once the previous edge was out of reset.
  sequence s_live;
    $past(i_rst_n);
  endsequence
  sequence s_cts_idle;
    $past(i_rst_n) ##0 !$past(i_mixed_periph_mode[4]);
  endsequence
  a_line_value: assert property (s_live |-> ((o_out_port_pin ^ $past(i_out_port_value))
    & ~$past(i_out_port_sel_mode)) == 8'h00) else $error("port line mismatch");
  a_select_low: assert property (s_live |->
    ((o_out_port_pin ^ ~hit_q) & $past(i_out_port_sel_mode)) == 8'h00) else $error("select bad");
  a_line_zero: assert property ($past(i_rst_n) && $past(i_mixed_line_zero_drive)
    && !$past(i_mixed_periph_mode[0]) |-> o_mixed_pin_oe[0]
    && o_mixed_pin_out[0] == $past(i_mixed_port_value[0])) else $error("line zero bad");
  a_read_pins: assert property (s_live |->
    o_mixed_port_read == ($past(i_mixed_pin) & PPD_MIX_READABLE)) else $error("read bad");
  a_out_only: assert property (s_live |-> o_mixed_pin_oe[1] && o_mixed_pin_oe[3])
    else $error("output line released");
  a_in_undriven: assert property ((o_mixed_pin_oe & PPD_MIX_IN_ONLY) == 8'h00)
    else $error("input line driven");
  a_open_drain: assert property (s_live |->
    o_mixed_pin_oe[7:6] == ~$past(i_mixed_port_value[7:6])
    && (o_mixed_pin_out[7:6] & o_mixed_pin_oe[7:6]) == 2'h0) else $error("open drain bad");
  a_periph_route: assert property ($past(i_rst_n) && $past(i_mixed_periph_mode[0])
    && $past(i_mixed_periph_mode[1]) |-> !o_mixed_pin_oe[0] && o_serial_one_receive
    == $past(i_mixed_pin[0]) && o_mixed_pin_out[1] == $past(i_serial_one_transmit))
    else $error("serial route bad");
  a_cts_idle: assert property (s_cts_idle |-> o_serial_one_clear_to_send_low)
    else $error("idle level bad");
endmodule
bind ppd_port_pins ppd_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

/* File: tb/ppd_pin_model.sv */
// Devices on the mixed port pins, with pull-ups on the open-drain lines.
`timescale 1ns/100ps
module ppd_pin_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_oe, i_out, i_ext_en, i_ext,
  output logic      [7:0] o_pin
);
  import ppd_pkg::*;
  logic [7:0] flip = 8'h00;
  // A floating push-pull line toggles so that a stale level is never read.
  always @(posedge i_clk)
    flip <= ~flip;
  always_comb
    for (int k = 0; k < 8; k++)
      if (PPD_MIX_OPEN_DR[k])
        o_pin[k] = !((i_oe[k] && !i_out[k]) || (i_ext_en[k] && !i_ext[k]));
      else
        o_pin[k] = i_oe[k] ? i_out[k] : (i_ext_en[k] ? i_ext[k] : flip[k]);
endmodule

/* File: tb/ppd_port_pins_test.sv */
// Self-checking bench for the port pin logic.
`timescale 1ns/100ps
module ppd_port_pins_test;
  import ppd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, io = 1'b0, drv = 1'b0, tx = 1'b0, sint = 1'b0;
  logic [19:0] adr = 20'h00000;
  logic [7:0] val = 8'h00, sel = 8'h00, en = 8'h00, sio = 8'h00, mv = 8'hc0, xen = 8'h00;
  logic [7:0] xv = 8'h00, opin, rd, mout, moe, pin;
  logic [7:0][19:0] sta, sto;
  logic [5:0] pm = 6'h00;
  logic rx, b1, cts, b0;
  int num_errors = 0, num_checks = 0;
  ppd_port_pins #(.ADDR_W(20)) i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_out_port_value(val),
    .i_out_port_sel_mode(sel), .i_bus_cycle(cyc), .i_bus_is_io(io), .i_bus_addr(adr),
    .i_sel_enable(en), .i_sel_is_io(sio), .i_sel_start(sta), .i_sel_stop(sto),
    .o_out_port_pin(opin), .i_mixed_port_value(mv), .i_mixed_line_zero_drive(drv),
    .i_mixed_periph_mode(pm), .o_mixed_port_read(rd), .i_mixed_pin(pin), .o_mixed_pin_out(mout),
    .o_mixed_pin_oe(moe), .i_serial_one_transmit(tx), .i_serial_one_interrupt(sint),
    .o_serial_one_receive(rx), .o_serial_one_baud_clock(b1),
    .o_serial_one_clear_to_send_low(cts), .o_serial_zero_baud_clock(b0));
  ppd_pin_model i_pins (.i_clk(clk), .i_oe(moe), .i_out(mout), .i_ext_en(xen), .i_ext(xv),
    .o_pin(pin));
  initial
    forever #50 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic t_select;
    sel = 8'hff;
    en = 8'h7f;
    sio = 8'haa;
    // Line seven is disabled; the third pass steps one past each range.
    for (int k = 0; k < 48; k++)
    begin
      cyc = 1'b1;
      adr = (k / 16 == 2) ? sto[k%8] + 20'h00001 : (k[3] ? sto[k%8] : sta[k%8]);
      io = sio[k%8] ^ (k / 16 == 1);
      @(negedge clk);
      chk("select", ~((8'h01 << (k % 8)) & en & {8{k < 16}}), opin);
    end
    sel = 8'h0f;
    adr = sta[0];
    io = sio[0];
    @(negedge clk);
    chk("select mix", {val[7:4], 4'he}, opin);
    cyc = 1'b0;
  endtask
  task automatic t_mixed;
    for (int k = 0; k < 8; k++)
    begin
      drv = k[2];
      mv = k[0] ? 8'h5a : 8'ha5;
      xv = k[1] ? 8'hff : 8'h00;
      xen = {7'h7a, !drv};
      repeat (2) @(negedge clk);
      chk("oe", {~mv[7:6], 5'h05, drv}, moe);
      chk("out", mv & {7'h05, drv}, mout & {7'h05, drv});
      chk("read", {mv[7:6] & xv[7:6], xv[5:1], drv ? mv[0] : xv[0]} & 8'hf5, rd);
    end
  endtask
  task automatic t_periph;
    mv = 8'hc0;
    xen = 8'h35;
    for (int k = 0; k < 4; k++)
    begin
      pm = {6{k < 3}};
      {sint, tx} = k[1:0];
      xv = k[0] ? 8'h21 : 8'h14;
      repeat (2) @(negedge clk);
      chk("oe", {7'h05, k == 3}, moe);
      chk("serial out", {6'h00, k == 3 ? {mv[3], mv[1]} : {sint, tx}}, {6'h00, mout[3], mout[1]});
      chk("serial in", k == 3 ? 8'h0a : {4'h0, xv[0], xv[2], xv[4], xv[5]},
        {4'h0, rx, b1, cts, b0});
    end
  endtask
  initial
  begin
    for (int k = 0; k < 8; k++)
    begin
      sta[k] = 20'(k) << 8;
      sto[k] = sta[k] + 20'h000ff;
    end
    repeat (3) @(negedge clk);
    chk("reset pins", PPD_RST_OUT_PIN, opin);
    chk("reset oe", PPD_RST_MIX_OE, moe);
    rst_n = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      val = (8'h01 << k[2:0]) ^ {8{k[3]}};
      @(negedge clk);
      chk("line", val, opin);
    end
    t_select;
    t_mixed;
    t_periph;
    complete_run;
  end
  initial
  begin
    #1000000;
    num_errors++;
    complete_run;
  end
endmodule
